// ==== common/asfl_cfg.svh ====
// Purpose: constants for the scan list and result queue block
// Assumes: byte offsets on a 16-bit host port
// Notes: definitions only
`ifndef ASFL_CFG_SVH
`define ASFL_CFG_SVH
`define ASFL_OFS_LIST_LOAD 5'h04
`define ASFL_OFS_LIST_CLEAR 5'h05
`define ASFL_OFS_LIST_WRITE 5'h06
`define ASFL_OFS_CMD1 5'h08
`define ASFL_OFS_STATUS 5'h0A
`define ASFL_OFS_ACQ_CLEAR 5'h0C
`define ASFL_OFS_RESULT_POP 5'h16
`define ASFL_LIST_DEPTH 512
`define ASFL_FIFO_DEPTH 8
`define ASFL_PEND_DEPTH 4
`define ASFL_BIT_SCAN_END 0
`define ASFL_BIT_DISCARD 8
`define ASFL_GAIN_LSB 1
`define ASFL_CHAN_LSB 4
`define ASFL_BIT_FORMAT 0
`define ASFL_BIT_ST_NOT_EMPTY 0
`define ASFL_BIT_ST_HALF_FULL_N 1
`define ASFL_BIT_ST_LIST_FULL_N 2
`define ASFL_BIT_ST_SCAN_END 3
`define ASFL_SAMPLE_SIGN 11
`define ASFL_ZERO16 16'h0000
`endif

// ==== common/asfl_pkg.sv ====
// Purpose: shared types for the scan list and result queue block
// Assumes: nothing
// Notes: list state enum and word and sample types
package asfl_pkg;
  typedef enum logic [1:0] {
    ASFL_IDLE = 2'b00,
    ASFL_PRIMED = 2'b01
  } asfl_list_state_t;
  typedef logic [15:0] asfl_word_t;
  typedef logic [11:0] asfl_sample_t;
endpackage

// ==== common/asfl_stream_if.sv ====
// Purpose: valid/ready stream between block and its queue
// Assumes: one clock
// Notes: data width is a parameter
`timescale 1ns/1ps
`default_nettype none
interface asfl_stream_if #(parameter int WIDTH = 12);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface // asfl_stream_if
`default_nettype wire

// ==== hdl/asfl_fifo.sv ====
// Purpose: result queue held in flip-flops
// Assumes: one clock, depth a power of two
// Notes: full input is refused, never overwritten
`timescale 1ns/1ps
`default_nettype none
module asfl_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Streams
  asfl_stream_if.sink in_s,
  asfl_stream_if.source out_s,
  // Fill level
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_s.valid && in_s.ready;
  wire pop = out_s.valid && out_s.ready;
  assign in_s.ready = (count != (AW+1)'(DEPTH));
  assign out_s.valid = (count != '0);
  assign out_s.data = mem[rd_ptr];
  assign count_o = count;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + AW'(1);
      if (pop) rd_ptr <= rd_ptr + AW'(1);
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // Data storage needs no reset
  always_ff @(posedge clock_i) begin
    if (push) mem[wr_ptr] <= in_s.data;
  end
endmodule // asfl_fifo
`default_nettype wire

// ==== hdl/asfl_scan_ctrl.sv ====
// Purpose: channel-gain scan list and result queue control
// Assumes: 16-bit host port with read/write strobes, 20 MHz clock
// Notes: conversion triggers arrive from pins and are synchronised
`timescale 1ns/1ps
`default_nettype none
`include "asfl_cfg.svh"
module asfl_scan_ctrl #(
  parameter int LIST_DEPTH = `ASFL_LIST_DEPTH,
  parameter int FIFO_DEPTH = `ASFL_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Host port
  input wire logic [4:0] host_addr_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [15:0] host_wdata_i,
  output logic [15:0] host_rdata_o,
  // Conversion triggers and converter
  input wire logic external_convert_n_i,
  input wire logic counter3_out_i,
  input wire logic conv_done_i,
  input wire logic [11:0] conv_data_i,
  output logic convert_start_o,
  // Analog front end
  output logic [3:0] input_channel_select_o,
  output logic [2:0] amplifier_gain_select_o
);
  localparam int LAW = $clog2(LIST_DEPTH);
  localparam int FCW = $clog2(FIFO_DEPTH) + 1;
  // A start beyond this many in flight loses its discard flag
  localparam int PEND_DEPTH = `ASFL_PEND_DEPTH;
  localparam int PIW = $clog2(PEND_DEPTH);
  localparam int PCW = PIW + 1;

  // Entry layout decoding, used to drive the selects from the applied entry
  function automatic logic [3:0] entry_chan(input logic [8:0] e);
    entry_chan = e[`ASFL_CHAN_LSB +: 4];
  endfunction
  function automatic logic [2:0] entry_gain(input logic [8:0] e);
    entry_gain = e[`ASFL_GAIN_LSB +: 3];
  endfunction

  // Host access decode
  wire wr_load = host_wr_i && (host_addr_i == `ASFL_OFS_LIST_LOAD);
  wire wr_clear = host_wr_i && (host_addr_i == `ASFL_OFS_LIST_CLEAR);
  wire wr_entry = host_wr_i && (host_addr_i == `ASFL_OFS_LIST_WRITE);
  wire wr_cmd1 = host_wr_i && (host_addr_i == `ASFL_OFS_CMD1);
  wire wr_acq_clear = host_wr_i && (host_addr_i == `ASFL_OFS_ACQ_CLEAR);
  wire rd_pop = host_rd_i && (host_addr_i == `ASFL_OFS_RESULT_POP);
  wire rd_status = host_rd_i && (host_addr_i == `ASFL_OFS_STATUS);
  wire rd_other = host_rd_i && !rd_pop && !rd_status;

  // List storage; entries kept 9 bits wide
  logic [8:0] list_mem [LIST_DEPTH];
  logic [LAW:0] list_len;
  logic [LAW-1:0] rd_pos;
  logic [8:0] applied;
  logic format_twos;
  asfl_pkg::asfl_list_state_t state;

  wire list_full = (list_len == (LAW+1)'(LIST_DEPTH));
  wire entry_accept = wr_entry && !list_full;
  wire load_ok = wr_load && (list_len != '0);
  wire [8:0] cur_entry = list_mem[rd_pos];
  wire [LAW-1:0] last_pos = LAW'(list_len - (LAW+1)'(1));
  wire at_end = (rd_pos == last_pos);
  wire [LAW-1:0] next_rd_pos = at_end ? '0 : rd_pos + LAW'(1);

  // Trigger synchronisers, two flip-flops each
  logic [1:0] ext_sync;
  logic [1:0] ctr_sync;
  logic ext_prev;
  logic ctr_prev;
  wire ext_edge = ext_prev && !ext_sync[1];
  wire ctr_edge = !ctr_prev && ctr_sync[1];
  wire primed = (state == asfl_pkg::ASFL_PRIMED);
  // Ignored unless primed, so an empty list never starts the converter
  wire conv_trig = primed && (ext_edge || ctr_edge);

  // Discard flag of each conversion in flight, oldest first
  logic [PEND_DEPTH-1:0] pend_discard;
  logic [PCW-1:0] pend_cnt;
  wire done_discard = pend_discard[0];

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_sync <= 2'b11;
      ctr_sync <= 2'b00;
      ext_prev <= 1'b1;
      ctr_prev <= 1'b0;
    end else begin
      ext_sync <= {ext_sync[0], external_convert_n_i};
      ctr_sync <= {ctr_sync[0], counter3_out_i};
      ext_prev <= ext_sync[1];
      ctr_prev <= ctr_sync[1];
    end
  end

  // List write side
  always_ff @(posedge clock_i) begin
    if (entry_accept) list_mem[LAW'(list_len)] <= host_wdata_i[8:0];
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      list_len <= '0;
    end else if (wr_clear) begin
      list_len <= '0;
    end else if (entry_accept) begin
      list_len <= list_len + (LAW+1)'(1);
    end
  end

  // List read side and primed state
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_pos <= '0;
      applied <= '0;
      state <= asfl_pkg::ASFL_IDLE;
    end else if (wr_clear) begin
      rd_pos <= '0;
      state <= asfl_pkg::ASFL_IDLE;
    end else if (wr_acq_clear) begin
      rd_pos <= '0;
      state <= asfl_pkg::ASFL_IDLE;
    end else if (load_ok) begin
      applied <= cur_entry;
      rd_pos <= next_rd_pos;
      state <= asfl_pkg::ASFL_PRIMED;
    end else begin
      case (state)
        asfl_pkg::ASFL_PRIMED: begin
          if (conv_trig) begin
            applied <= cur_entry;
            rd_pos <= next_rd_pos;
          end
        end
        default: state <= asfl_pkg::ASFL_IDLE;
      endcase
    end
  end

  // Scan-end entries are not special for stepping; wrap only at list end
  wire scan_end_seen = applied[`ASFL_BIT_SCAN_END];

  // Pending discard tracking; conversion starts on trigger with applied entry
  logic [8:0] conv_entry;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      convert_start_o <= 1'b0;
      conv_entry <= '0;
    end else begin
      convert_start_o <= conv_trig;
      if (conv_trig) conv_entry <= applied;
    end
  end

  wire pend_full = (pend_cnt == PCW'(PEND_DEPTH));
  wire pend_empty = (pend_cnt == '0);
  wire pend_push = convert_start_o && !pend_full;
  wire pend_pop = conv_done_i && !pend_empty;
  wire [PIW-1:0] pend_slot = PIW'(pend_cnt - PCW'(pend_pop));
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pend_discard <= '0;
      pend_cnt <= '0;
    end else begin
      if (pend_pop) pend_discard <= {1'b0, pend_discard[PEND_DEPTH-1:1]};
      if (pend_push) begin
        pend_discard[pend_slot] <= conv_entry[`ASFL_BIT_DISCARD];
      end
      pend_cnt <= pend_cnt + PCW'(pend_push) - PCW'(pend_pop);
    end
  end

  // Result queue
  asfl_stream_if #(.WIDTH(12)) q_in();
  asfl_stream_if #(.WIDTH(12)) q_out();
  logic [FCW-1:0] q_count;
  assign q_in.valid = conv_done_i && !done_discard;
  assign q_in.data = conv_data_i;
  // Full queue refuses the push, so the sample is lost
  assign q_out.ready = rd_pop;

  asfl_fifo #(.WIDTH(12), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .in_s(q_in),
    .out_s(q_out),
    .count_o(q_count)
  );

  // Format select
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) format_twos <= 1'b0;
    else if (wr_cmd1) format_twos <= host_wdata_i[`ASFL_BIT_FORMAT];
  end

  wire [11:0] sample = q_out.data;
  wire inv_msb = ~sample[`ASFL_SAMPLE_SIGN];
  wire [15:0] fmt_bin = {4'h0, sample};
  wire [15:0] fmt_twos = {{5{inv_msb}}, sample[`ASFL_SAMPLE_SIGN-1:0]};
  wire [15:0] fmt_out = format_twos ? fmt_twos : fmt_bin;
  wire not_empty = q_out.valid;
  wire half_full_n = (q_count < FCW'(FIFO_DEPTH / 2));
  logic [15:0] status_word;
  always_comb begin
    status_word = `ASFL_ZERO16;
    status_word[`ASFL_BIT_ST_NOT_EMPTY] = not_empty;
    status_word[`ASFL_BIT_ST_HALF_FULL_N] = half_full_n;
    status_word[`ASFL_BIT_ST_LIST_FULL_N] = !list_full;
    status_word[`ASFL_BIT_ST_SCAN_END] = scan_end_seen;
  end

  // Registered read data; empty reads give stale, meaningless data
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      host_rdata_o <= `ASFL_ZERO16;
    end else if (rd_pop) begin
      host_rdata_o <= fmt_out;
    end else if (rd_status) begin
      host_rdata_o <= status_word;
    end else if (rd_other) begin
      host_rdata_o <= `ASFL_ZERO16;
    end
  end

  assign input_channel_select_o = entry_chan(applied);
  assign amplifier_gain_select_o = entry_gain(applied);
endmodule // asfl_scan_ctrl
`default_nettype wire

// ==== verif/asfl_conv_model.sv ====
// Purpose: converter stand-in for the scan block
// Assumes: fixed latency after each start pulse
// Notes: data toggles when idle so stale values never pass
`timescale 1ns/1ps
`default_nettype none
module asfl_conv_model #(
  parameter int LAT = 3
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Block side
  input wire logic start_i,
  input wire logic [11:0] sample_i,
  output logic done_o,
  output logic [11:0] data_o
);
  int cnt;
  logic [11:0] held;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt <= 0;
      held <= 12'h000;
      done_o <= 1'b0;
      data_o <= 12'h000;
    end else begin
      done_o <= (cnt == 1);
      data_o <= (cnt == 1) ? held : ~data_o;
      if (start_i) begin
        cnt <= LAT;
        held <= sample_i;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule // asfl_conv_model
`default_nettype wire

// ==== verif/asfl_scan_ctrl_sva.sv ====
// Purpose: port checks for the scan list block
// Assumes: read data settled two cycles after a read
// Notes: no pop is made on an empty queue
`timescale 1ns/1ps
`default_nettype none
`include "asfl_cfg.svh"
module asfl_scan_ctrl_sva #(
  parameter int LIST_DEPTH = 512,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Host port
  input wire logic [4:0] host_addr_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [15:0] host_wdata_i,
  input wire logic [15:0] host_rdata_o,
  // Converter and front end
  input wire logic external_convert_n_i,
  input wire logic counter3_out_i,
  input wire logic conv_done_i,
  input wire logic [11:0] conv_data_i,
  input wire logic convert_start_o,
  input wire logic [3:0] input_channel_select_o,
  input wire logic [2:0] amplifier_gain_select_o
);
  logic ext_q, ctr_q, fmt_q, seen_q;
  logic [7:0] trig_h;
  logic [1:0] wr_h;
  // Raw pin edges kept 8 cycles, wide enough for the 2-stage sync
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_q <= 1'b1;
      {ctr_q, fmt_q, seen_q, trig_h, wr_h} <= 13'h0000;
    end else begin
      ext_q <= external_convert_n_i;
      ctr_q <= counter3_out_i;
      trig_h <= {trig_h[6:0], (ext_q & ~external_convert_n_i) | (~ctr_q & counter3_out_i)};
      wr_h <= {wr_h[0], host_wr_i};
      seen_q <= seen_q | conv_done_i;
      if (host_wr_i && host_addr_i == `ASFL_OFS_CMD1) fmt_q <= host_wdata_i[`ASFL_BIT_FORMAT];
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_pop; host_rd_i && host_addr_i == `ASFL_OFS_RESULT_POP; endsequence
  sequence s_stat; host_rd_i && host_addr_i == `ASFL_OFS_STATUS; endsequence
  sequence s_clr; host_wr_i && host_addr_i == `ASFL_OFS_LIST_CLEAR; endsequence
  property p_start_pulse; convert_start_o |=> !convert_start_o; endproperty
  property p_start_cause; convert_start_o |-> (|trig_h); endproperty
  property p_sel_cause;
    !$stable({input_channel_select_o, amplifier_gain_select_o}) |-> (|{trig_h, wr_h});
  endproperty
  property p_rd_hold; !host_rd_i [*3] |-> $stable(host_rdata_o); endproperty
  property p_bin; s_pop ##0 !fmt_q |-> ##2 host_rdata_o[15:12] == 4'h0; endproperty
  property p_twos; s_pop ##0 fmt_q |-> ##2 host_rdata_o[15:11] inside {5'h00, 5'h1F}; endproperty
  property p_flags; s_stat |-> ##2 (host_rdata_o[1] || host_rdata_o[0]); endproperty
  property p_fresh; s_stat ##0 !seen_q |-> ##2 !host_rdata_o[0]; endproperty
  property p_clr_room; s_clr ##[1:2] s_stat |-> ##2 host_rdata_o[2]; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  a_start_cause: assert property (p_start_cause) else $error("start without trigger");
  a_sel_cause: assert property (p_sel_cause) else $error("select moved alone");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_bin: assert property (p_bin) else $error("binary top bits set");
  a_twos: assert property (p_twos) else $error("sign not extended");
  a_flags: assert property (p_flags) else $error("half full but empty");
  a_fresh: assert property (p_fresh) else $error("not empty before data");
  a_clr_room: assert property (p_clr_room) else $error("full after clear");
endmodule // asfl_scan_ctrl_sva
bind asfl_scan_ctrl asfl_scan_ctrl_sva #(.LIST_DEPTH(LIST_DEPTH), .FIFO_DEPTH(FIFO_DEPTH))
  i_asfl_scan_ctrl_sva (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .host_addr_i(host_addr_i),
    .host_wr_i(host_wr_i),
    .host_rd_i(host_rd_i),
    .host_wdata_i(host_wdata_i),
    .host_rdata_o(host_rdata_o),
    .external_convert_n_i(external_convert_n_i),
    .counter3_out_i(counter3_out_i),
    .conv_done_i(conv_done_i),
    .conv_data_i(conv_data_i),
    .convert_start_o(convert_start_o),
    .input_channel_select_o(input_channel_select_o),
    .amplifier_gain_select_o(amplifier_gain_select_o)
  );
`default_nettype wire

// ==== verif/tb_top.sv ====
// Purpose: directed bench for the scan list block
// Assumes: converter answers three cycles after start
// Notes: the first pop and the first drain-loop pop follow a status read; other pops follow writes or other pops
`timescale 1ns/1ps
`default_nettype none
`include "asfl_cfg.svh"
module tb_top;
  localparam logic [4:0] CL_A = `ASFL_OFS_LIST_CLEAR, WR_A = `ASFL_OFS_LIST_WRITE;
  localparam logic [4:0] LD_A = `ASFL_OFS_LIST_LOAD, ST_A = `ASFL_OFS_STATUS;
  localparam logic [4:0] POP_A = `ASFL_OFS_RESULT_POP;
  localparam logic [15:0] E0 = 16'h0034, E1 = 16'h0053, E2 = 16'h019F;
  logic clock_i = 1'b0, reset_n_i = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
  logic ext_n = 1'b1, ctr3 = 1'b0, start, done;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000, rdata, got, sel;
  logic [11:0] sample = 12'h000, cdata;
  logic [3:0] chan;
  logic [2:0] gain;
  int err_total = 0;
  int checks_done = 0;
  assign sel = {9'h000, chan, gain};
  always #25 clock_i = ~clock_i;
  asfl_scan_ctrl i_asfl_scan_ctrl (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .host_addr_i(addr), .host_wr_i(wr_s),
    .host_rd_i(rd_s), .host_wdata_i(wdata), .host_rdata_o(rdata),
    .external_convert_n_i(ext_n), .counter3_out_i(ctr3), .conv_done_i(done),
    .conv_data_i(cdata), .convert_start_o(start), .input_channel_select_o(chan),
    .amplifier_gain_select_o(gain));
  asfl_conv_model i_asfl_conv_model (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .start_i(start), .sample_i(sample), .done_o(done), .data_o(cdata));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clock_i);
    wr_s <= 1'b0;
  endtask
  // Data read late: it stands until the next read anyway
  task automatic rd(input logic [4:0] a);
    @(posedge clock_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock_i);
    rd_s <= 1'b0;
    @(posedge clock_i);
    @(negedge clock_i);
    got = rdata;
  endtask
  // Pin held until done, then rested so the sync sees a clean edge next time
  task automatic trig(input logic use_ext, input logic [11:0] s);
    int n;
    n = 0;
    @(posedge clock_i);
    sample <= s;
    ext_n <= !use_ext;
    ctr3 <= !use_ext;
    while (done !== 1'b1 && n < 20) begin
      @(posedge clock_i);
      n++;
    end
    ext_n <= 1'b1;
    ctr3 <= 1'b0;
    repeat (4) @(posedge clock_i);
    if (n >= 20) begin
      err_total++;
      wrap_up();
    end
  endtask
  initial begin
    repeat (12) @(posedge clock_i);
    reset_n_i <= 1'b1;
    rd(ST_A);
    chk(got & 16'h0007, 16'h0006);
    wr(CL_A, 16'h0000);
    wr(WR_A, E0);
    wr(WR_A, E1);
    wr(WR_A, E2);
    wr(LD_A, 16'h0000);
    repeat (2) @(negedge clock_i);
    chk(sel, {9'h000, E0[7:1]});
    trig(1'b1, 12'hABC);
    chk(sel, {9'h000, E1[7:1]});
    rd(ST_A);
    chk(got & 16'h0008, 16'h0008);
    trig(1'b0, 12'h123);
    chk(sel, {9'h000, E2[7:1]});
    trig(1'b1, 12'h456);
    chk(sel, {9'h000, E0[7:1]});
    rd(ST_A);
    chk(got & 16'h0001, 16'h0001);
    rd(POP_A);
    chk(got, 16'h0ABC);
    wr(`ASFL_OFS_CMD1, 16'h0001);
    rd(POP_A);
    chk(got, 16'hF923);
    rd(ST_A);
    chk(got & 16'h0001, 16'h0000);
    trig(1'b1, 12'h7FF);
    wr(`ASFL_OFS_ACQ_CLEAR, 16'h0000);
    wr(LD_A, 16'h0000);
    repeat (2) @(negedge clock_i);
    chk(sel, {9'h000, E0[7:1]});
    rd(POP_A);
    chk(got, 16'hFFFF);
    wr(CL_A, 16'h0000);
    rd(ST_A);
    chk(got & 16'h0004, 16'h0004);
    wr(WR_A, E1);
    wr(LD_A, 16'h0000);
    repeat (2) @(negedge clock_i);
    chk(sel, {9'h000, E1[7:1]});
    for (int i = 0; i < 10; i++) trig(i[0], 12'h800 + i[11:0]);
    chk(sel, {9'h000, E1[7:1]});
    rd(ST_A);
    chk(got & 16'h0003, 16'h0001);
    for (int i = 0; i < 8; i++) begin
      rd(POP_A);
      chk(got, i[15:0]);
    end
    rd(ST_A);
    chk(got & 16'h0003, 16'h0002);
    wr(CL_A, 16'h0000);
    for (int i = 0; i < 511; i++) wr(WR_A, E0);
    rd(ST_A);
    chk(got & 16'h0004, 16'h0004);
    wr(WR_A, E0);
    rd(ST_A);
    chk(got & 16'h0004, 16'h0000);
    wr(WR_A, E1);
    wr(LD_A, 16'h0000);
    repeat (2) @(negedge clock_i);
    chk(sel, {9'h000, E0[7:1]});
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
